// [rtl/ics_irq.sv]
// Purpose: Sticky raw interrupt flags with a mask onto one output.
// Assumes: Events and clears are single-cycle pulses on mclk_i.
// Notes:   A set in the same cycle as its clear wins.
`timescale 1ns/10ps
`default_nettype none
module ics_irq #(
  parameter int N = 10
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] ev_i,
  input  wire logic [N-1:0] clr_i,
  input  wire logic [N-1:0] mask_i,
  output logic      [N-1:0] raw_o,
  output logic              irq_o
);
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      raw_o <= '0;
      irq_o <= 1'b0;
    end else begin
      raw_o <= ev_i | (raw_o & ~clr_i);
      irq_o <= |((ev_i | (raw_o & ~clr_i)) & mask_i);
    end
  end
endmodule
`default_nettype wire

// [rtl/ics_pkg.sv]
// Purpose: Shared constants of the command-driven two-wire controller.
// Assumes: 100 MHz functional clock.
// Notes:   Command word is op(3), ack value, ack expected, ack check, byte count(8).
package ics_pkg;
  localparam int CMD_N    = 16;
  localparam int RAM_N    = 32;
  localparam int IRQ_N    = 10;
  localparam int CMD_W    = 14;
  // Operation codes of a command entry.
  localparam logic [2:0] OP_START = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_READ  = 3'h2;
  localparam logic [2:0] OP_STOP  = 3'h3;
  localparam logic [2:0] OP_END   = 3'h4;
  // Field positions inside a command entry.
  localparam int CF_OP_HI = 13;
  localparam int CF_OP_LO = 11;
  localparam int CF_ACKV  = 10;
  localparam int CF_ACKE  = 9;
  localparam int CF_ACKC  = 8;
  // Interrupt event positions.
  localparam int IR_TXCH   = 0;
  localparam int IR_RXCH   = 1;
  localparam int IR_ACKERR = 2;
  localparam int IR_START  = 3;
  localparam int IR_TOUT   = 4;
  localparam int IR_COMP   = 5;
  localparam int IR_BYTE   = 6;
  localparam int IR_ARB    = 7;
  localparam int IR_SLCOMP = 8;
  localparam int IR_END    = 9;
  // Serial clock rate and the quarter bit time derived from it.
  localparam int CLK_KHZ  = 100000;
  localparam int SCL_KHZ  = 100;
  localparam int QTR_CYC  = CLK_KHZ / (4 * SCL_KHZ);
  // Addressing and slave limits.
  localparam logic [4:0] ADDR10_HDR = 5'h1e;
  localparam logic [5:0] SL_MAX     = 6'h20;
  localparam logic [3:0] ACK_BIT    = 4'h8;
  localparam logic [3:0] LAST_BIT   = 4'h7;
endpackage

// [rtl/ics_sync.sv]
// Purpose: Two flip-flop synchroniser for the bus pins.
// Assumes: Inputs are asynchronous to mclk_i.
// Notes:   Only the second stage is visible.
`timescale 1ns/10ps
`default_nettype none
module ics_sync #(
  parameter int W = 2
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= {W{1'b1}};
      q_o      <= {W{1'b1}};
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// [rtl/ics_top.sv]
// Purpose: Command-driven two-wire controller, master and slave roles.
// Assumes: Open-drain pins; an enable high pulls the line low.
// Notes:   Shared 32-byte data store and 16-entry command list.
// Operation
// - Seven-bit addressing unless wide mode selected.
// - Ten-bit master sends second address byte next.
// - Wide-address slave matches ten-bit own address.
// - Ten-bit write: fourteen 255-byte WRITE commands.
// - Register pointer slave write, 32 bytes maximum.
// - END stops clock, holds SCL low, flags.
// - Bus held until STOP is sent.
// - Master acknowledges with READ command's value.
// - Read bytes stored from first location.
// - Read list: start, WRITE, 13 READ, STOP.
// - Ten-bit read address uses two bytes.
// - Pointer slave sends bytes from pointer.
// - Chunk flags after threshold bytes sent/received.
// - Acknowledge error on mismatch or slave NACK.
// - Timeout when SCL level outlasts count.
// - Complete on STOP, slave complete, start sent.
// - Master byte-done flag per byte.
// - Arbitration lost when SDA differs, SCL high.
// - Three-bit operation codes zero through four.
`timescale 1ns/10ps
`default_nettype none
module ics_top #(
  parameter int TO_W = 20,
  parameter int QTR  = ics_pkg::QTR_CYC
) (
  input  wire logic            mclk_i,
  input  wire logic            rst_i,
  input  wire logic            ms_mode_i,
  input  wire logic            launch_bit_i,
  input  wire logic            slave_wide_addr_enable_i,
  input  wire logic            reg_ptr_en_i,
  input  wire logic [9:0]      own_addr_i,
  input  wire logic [7:0]      tx_thres_i,
  input  wire logic [7:0]      rx_thres_i,
  input  wire logic [TO_W-1:0] timeout_i,
  input  wire logic            cmd_we_i,
  input  wire logic [3:0]      cmd_idx_i,
  input  wire logic [13:0]     cmd_wdata_i,
  input  wire logic            ram_we_i,
  input  wire logic [4:0]      ram_addr_i,
  input  wire logic [7:0]      ram_wdata_i,
  output logic      [7:0]      ram_rdata_o,
  input  wire logic [9:0]      irq_mask_i,
  input  wire logic [9:0]      irq_clr_i,
  output logic      [9:0]      irq_raw_o,
  output logic                 irq_o,
  output logic      [15:0]     cmd_done_o,
  output logic                 bus_busy_o,
  output logic                 slave_addressed_o,
  output logic                 master_held_o,
  input  wire logic            scl_i,
  output logic                 scl_o,
  output logic                 scl_oe_o,
  input  wire logic            sda_i,
  output logic                 sda_o,
  output logic                 sda_oe_o
);
  if (QTR < 2 || QTR > 65536 || TO_W < 2) begin : g_chk
    $error("ics_top: QTR must be 2 to 65536 and TO_W at least 2.");
  end

  typedef enum logic [2:0] {M_IDLE, M_FETCH, M_START, M_BITS, M_STOP, M_HOLD} ics_mst_t;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ADDR2, S_RX, S_TX} ics_slv_t;

  logic [1:0]  pin_s;
  logic        scl_s, sda_s, scl_q, sda_q;
  logic        start_det, stop_det, scl_rise, scl_fall;
  logic [13:0] cmd_mem [ics_pkg::CMD_N];
  logic [7:0]  ram [ics_pkg::RAM_N];
  ics_mst_t    m_st;
  logic [1:0]  m_q;
  logic [15:0] m_qc;
  logic        m_tick;
  logic [3:0]  m_pc, m_bit;
  logic [7:0]  m_left, m_sh;
  logic [13:0] m_cmd;
  logic        m_rd, m_err, m_own, m_wr;
  logic        m_scl_low, m_sda_low;
  logic [4:0]  m_tx_ptr, m_rx_ptr, m_wa;
  logic [2:0]  f_op;
  logic        ev_start, ev_byte, ev_mtx, ev_arb, ev_mack, ev_end;
  ics_slv_t    s_st;
  logic [3:0]  s_bit;
  logic [7:0]  s_sh, s_tx;
  logic [4:0]  s_ptr, s_wa;
  logic [5:0]  s_cnt;
  logic        s_first, s_hit, s_drv, s_wr, ev_sack, ev_stx;
  logic [7:0]  tx_cnt, rx_cnt;
  logic [TO_W-1:0] to_cnt;
  logic [9:0]  ev;

  ics_sync #(.W(2)) u_sync (
    .mclk_i(mclk_i),
    .rst_i (rst_i),
    .d_i   ({scl_i, sda_i}),
    .q_o   (pin_s)
  );

  assign scl_s     = pin_s[1];
  assign sda_s     = pin_s[0];
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      bus_busy_o <= 1'b0;
    end else begin
      scl_q      <= scl_s;
      sda_q      <= sda_s;
      bus_busy_o <= start_det | (bus_busy_o & ~stop_det);
    end
  end

  // Software writes the command list; storage needs no reset.
  always_ff @(posedge mclk_i) begin
    if (cmd_we_i) begin
      cmd_mem[cmd_idx_i] <= cmd_wdata_i;
    end
  end

  // Data store: engine writes take priority over software writes.
  always_ff @(posedge mclk_i) begin
    if (m_wr) begin
      ram[m_wa] <= m_sh;
    end else if (s_wr) begin
      ram[s_wa] <= s_sh;
    end else if (ram_we_i) begin
      ram[ram_addr_i] <= ram_wdata_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ram_rdata_o <= 8'h00;
    end else begin
      ram_rdata_o <= ram[ram_addr_i];
    end
  end

  assign f_op   = cmd_mem[m_pc][ics_pkg::CF_OP_HI:ics_pkg::CF_OP_LO];
  assign m_tick = (m_qc == 16'(QTR - 1)) && !(m_st == M_BITS && m_q == 2'h2 && !scl_s);

  // Master sequencer: fetches a command, then runs quarter-bit phases.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      m_st <= M_IDLE; m_q <= 2'h0; m_qc <= 16'h0000; m_pc <= 4'h0; m_bit <= 4'h0;
      m_left <= 8'h00; m_sh <= 8'h00; m_cmd <= 14'h0000; m_rd <= 1'b0; m_err <= 1'b0;
      m_own <= 1'b0; m_wr <= 1'b0; m_scl_low <= 1'b0; m_sda_low <= 1'b0;
      m_tx_ptr <= 5'h00; m_rx_ptr <= 5'h00; m_wa <= 5'h00; cmd_done_o <= 16'h0000;
      ev_start <= 1'b0; ev_byte <= 1'b0; ev_mtx <= 1'b0; ev_arb <= 1'b0; ev_mack <= 1'b0; ev_end <= 1'b0;
    end else begin
      m_wr <= 1'b0; ev_start <= 1'b0; ev_byte <= 1'b0; ev_mtx <= 1'b0;
      ev_arb <= 1'b0; ev_mack <= 1'b0; ev_end <= 1'b0;
      if (m_st == M_START || m_st == M_BITS || m_st == M_STOP) begin
        m_qc <= m_tick ? 16'h0000 : m_qc + 16'h0001;
      end else begin
        m_qc <= 16'h0000;
      end
      case (m_st)
        M_IDLE, M_HOLD: begin
          if (launch_bit_i && ms_mode_i && (m_st == M_HOLD || scl_s)) begin
            m_pc <= 4'h0; m_tx_ptr <= 5'h00; m_rx_ptr <= 5'h00;
            cmd_done_o <= 16'h0000; m_err <= 1'b0;
            m_st <= M_FETCH;
          end
        end
        M_FETCH: begin
          m_cmd <= cmd_mem[m_pc]; m_q <= 2'h0; m_bit <= 4'h0;
          m_left <= cmd_mem[m_pc][7:0];
          m_rd <= (f_op == ics_pkg::OP_READ);
          m_sh <= ram[m_tx_ptr];
          case (f_op)
            ics_pkg::OP_START: m_st <= M_START;
            ics_pkg::OP_WRITE: begin
              m_tx_ptr <= m_tx_ptr + 5'h01;
              m_st <= M_BITS;
            end
            ics_pkg::OP_READ:  m_st <= M_BITS;
            ics_pkg::OP_STOP:  m_st <= M_STOP;
            ics_pkg::OP_END: begin
              m_scl_low <= 1'b1; ev_end <= 1'b1; cmd_done_o[m_pc] <= 1'b1;
              m_st <= M_HOLD;
            end
            default: m_st <= M_IDLE;
          endcase
        end
        M_START: if (m_tick) begin
          m_q <= m_q + 2'h1;
          case (m_q)
            2'h0: m_sda_low <= 1'b0;
            2'h1: m_scl_low <= 1'b0;
            2'h2: m_sda_low <= 1'b1;
            default: begin
              m_scl_low <= 1'b1; m_own <= 1'b1; ev_start <= 1'b1;
              cmd_done_o[m_pc] <= 1'b1; m_pc <= m_pc + 4'h1; m_st <= M_FETCH;
            end
          endcase
        end
        M_STOP: if (m_tick) begin
          m_q <= m_q + 2'h1;
          case (m_q)
            2'h0: m_sda_low <= 1'b1;
            2'h1: m_scl_low <= 1'b0;
            2'h2: m_sda_low <= 1'b0;
            default: begin
              m_own <= 1'b0; cmd_done_o[m_pc] <= 1'b1; m_st <= M_IDLE;
            end
          endcase
        end
        M_BITS: if (m_tick) begin
          m_q <= m_q + 2'h1;
          case (m_q)
            2'h0: begin
              if (m_bit == ics_pkg::ACK_BIT) begin
                m_sda_low <= m_rd & ~m_cmd[ics_pkg::CF_ACKV];
              end else begin
                m_sda_low <= ~m_rd & ~m_sh[7];
              end
            end
            2'h1: m_scl_low <= 1'b0;
            2'h2: begin
              if ((m_rd == (m_bit == ics_pkg::ACK_BIT)) && (sda_s == m_sda_low)) begin
                ev_arb <= 1'b1; m_scl_low <= 1'b0; m_sda_low <= 1'b0;
                m_own <= 1'b0; m_st <= M_IDLE;
              end else if (m_bit != ics_pkg::ACK_BIT) begin
                m_sh <= {m_sh[6:0], sda_s};
              end else if (!m_rd && m_cmd[ics_pkg::CF_ACKC] && sda_s != m_cmd[ics_pkg::CF_ACKE]) begin
                ev_mack <= 1'b1; m_err <= 1'b1;
              end
            end
            default: begin
              m_scl_low <= 1'b1;
              if (m_bit != ics_pkg::ACK_BIT) begin
                m_bit <= m_bit + 4'h1;
              end else begin
                m_bit <= 4'h0; ev_byte <= 1'b1; ev_mtx <= ~m_rd;
                m_left <= m_left - 8'h01;
                if (m_rd) begin
                  m_wr <= 1'b1; m_wa <= m_rx_ptr; m_rx_ptr <= m_rx_ptr + 5'h01;
                end else begin
                  m_sh <= ram[m_tx_ptr]; m_tx_ptr <= m_tx_ptr + 5'h01;
                end
                if (m_err) begin
                  m_st <= M_STOP;
                end else if (m_left <= 8'h01) begin
                  cmd_done_o[m_pc] <= 1'b1; m_pc <= m_pc + 4'h1; m_st <= M_FETCH;
                end
              end
            end
          endcase
        end
        default: m_st <= M_IDLE;
      endcase
    end
  end

  // Slave engine: follows bus edges, matches address, stores or sends bytes.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_st <= S_IDLE; s_bit <= 4'h0; s_sh <= 8'h00; s_tx <= 8'h00; s_ptr <= 5'h00; s_wa <= 5'h00;
      s_cnt <= 6'h00; s_first <= 1'b0; s_hit <= 1'b0; s_drv <= 1'b0; s_wr <= 1'b0;
      ev_sack <= 1'b0; ev_stx <= 1'b0;
    end else begin
      s_wr <= 1'b0; ev_sack <= 1'b0; ev_stx <= 1'b0;
      if (ms_mode_i) begin
        s_st <= S_IDLE; s_drv <= 1'b0; s_hit <= 1'b0;
      end else if (start_det) begin
        s_st <= S_ADDR; s_bit <= 4'h0; s_drv <= 1'b0; s_first <= 1'b1; s_cnt <= 6'h00;
        if (!reg_ptr_en_i) begin
          s_ptr <= 5'h00;
        end
      end else if (stop_det) begin
        s_st <= S_IDLE; s_drv <= 1'b0; s_hit <= 1'b0;
      end else if (scl_rise && s_st != S_IDLE) begin
        if (s_bit != ics_pkg::ACK_BIT) begin
          s_sh <= {s_sh[6:0], sda_s};
        end else if (s_st == S_TX && sda_s) begin
          ev_sack <= 1'b1; s_st <= S_IDLE;
        end
      end else if (scl_fall && s_st != S_IDLE) begin
        if (s_bit == ics_pkg::LAST_BIT) begin
          s_bit <= ics_pkg::ACK_BIT; s_drv <= 1'b0; s_st <= S_IDLE;
          case (s_st)
            S_ADDR: if (slave_wide_addr_enable_i) begin
              if (s_sh[7:3] == ics_pkg::ADDR10_HDR && s_sh[2:1] == own_addr_i[9:8]) begin
                if (!s_sh[0]) begin
                  s_drv <= 1'b1; s_st <= S_ADDR2;
                end else if (s_hit) begin
                  s_drv <= 1'b1; s_st <= S_TX;
                end
              end
            end else if (s_sh[7:1] == own_addr_i[6:0]) begin
              s_drv <= 1'b1; s_hit <= 1'b1; s_st <= s_sh[0] ? S_TX : S_RX;
            end
            S_ADDR2: if (s_sh == own_addr_i[7:0]) begin
              s_drv <= 1'b1; s_hit <= 1'b1; s_st <= S_RX;
            end
            S_RX: begin
              s_st <= S_RX; s_first <= 1'b0;
              if (s_first && reg_ptr_en_i) begin
                s_ptr <= s_sh[4:0]; s_drv <= 1'b1;
              end else if (s_cnt < ics_pkg::SL_MAX) begin
                s_wr <= 1'b1; s_wa <= s_ptr; s_ptr <= s_ptr + 5'h01;
                s_cnt <= s_cnt + 6'h01; s_drv <= 1'b1;
              end
            end
            default: begin
              s_st <= S_TX; ev_stx <= 1'b1;
            end
          endcase
        end else if (s_bit == ics_pkg::ACK_BIT) begin
          s_bit <= 4'h0; s_drv <= 1'b0;
          if (s_st == S_TX) begin
            s_drv <= ~ram[s_ptr][7]; s_tx <= {ram[s_ptr][6:0], 1'b0};
            s_ptr <= s_ptr + 5'h01;
          end
        end else begin
          s_bit <= s_bit + 4'h1;
          if (s_st == S_TX) begin
            s_drv <= ~s_tx[7]; s_tx <= {s_tx[6:0], 1'b0};
          end
        end
      end
    end
  end

  // Chunk counters restart with every START seen on the bus.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_cnt <= 8'h00;
      rx_cnt <= 8'h00;
    end else if (start_det) begin
      tx_cnt <= 8'h00;
      rx_cnt <= 8'h00;
    end else begin
      tx_cnt <= tx_cnt + {7'h00, ev_mtx | ev_stx};
      rx_cnt <= rx_cnt + {7'h00, m_wr | s_wr};
    end
  end

  // Timeout counter saturates so that each long level fires once, unless timeout_i is all ones.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      to_cnt <= '0;
    end else if (scl_s != scl_q) begin
      to_cnt <= '0;
    end else if (to_cnt != {TO_W{1'b1}}) begin
      to_cnt <= to_cnt + 1'b1;
    end
  end

  always_comb begin
    ev = '0;
    ev[ics_pkg::IR_TXCH]   = (ev_mtx | ev_stx) && (tx_cnt + 8'h01 == tx_thres_i);
    ev[ics_pkg::IR_RXCH]   = (m_wr | s_wr) && (rx_cnt + 8'h01 == rx_thres_i);
    ev[ics_pkg::IR_ACKERR] = ev_mack | ev_sack;
    ev[ics_pkg::IR_START]  = ev_start;
    ev[ics_pkg::IR_TOUT]   = (scl_s == scl_q) && (to_cnt == timeout_i);
    ev[ics_pkg::IR_COMP]   = stop_det;
    ev[ics_pkg::IR_BYTE]   = ev_byte;
    ev[ics_pkg::IR_ARB]    = ev_arb;
    ev[ics_pkg::IR_SLCOMP] = stop_det & ~ms_mode_i;
    ev[ics_pkg::IR_END]    = ev_end;
  end

  ics_irq #(.N(ics_pkg::IRQ_N)) u_irq (
    .mclk_i(mclk_i),
    .rst_i (rst_i),
    .ev_i  (ev),
    .clr_i (irq_clr_i),
    .mask_i(irq_mask_i),
    .raw_o (irq_raw_o),
    .irq_o (irq_o)
  );

  assign scl_o             = 1'b0;
  assign sda_o             = 1'b0;
  assign scl_oe_o          = m_scl_low;
  assign sda_oe_o          = m_sda_low | s_drv;
  assign slave_addressed_o = s_hit;
  assign master_held_o     = (m_st == M_HOLD);

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  a_end_holds_scl: assert property (m_st == M_HOLD |-> scl_oe_o)
    else $error("SCL not held low while held.");
  a_end_flag_set: assert property (ev_end |-> m_st == M_HOLD ##1 irq_raw_o[ics_pkg::IR_END])
    else $error("End flag not raised on END.");
  a_release_on_stop: assert property ($fell(m_own) |-> $past(m_st == M_STOP) || ev_arb)
    else $error("Bus released without a STOP.");
  a_read_ack_value: assert property (m_st == M_BITS && m_rd && m_bit == 4'h8 && m_q == 2'h1
                                     |-> sda_oe_o == !m_cmd[ics_pkg::CF_ACKV])
    else $error("Read acknowledge differs from command.");
  a_read_from_zero: assert property ((m_st == M_IDLE || m_st == M_HOLD) && launch_bit_i && ms_mode_i && scl_s
                                     |=> m_rx_ptr == 5'h00 && m_st == M_FETCH)
    else $error("Read pointer not restarted on launch.");
  a_stop_flags: assert property (stop_det |=> irq_raw_o[ics_pkg::IR_COMP]
                                 && ($past(ms_mode_i) || irq_raw_o[ics_pkg::IR_SLCOMP]))
    else $error("STOP not flagged.");
  a_arb_release: assert property (ev[ics_pkg::IR_ARB] |-> !sda_oe_o && !scl_oe_o && m_st == M_IDLE ##1
                                  irq_raw_o[ics_pkg::IR_ARB])
    else $error("Lost arbitration did not release the bus.");
  a_timeout_flag: assert property (scl_s == scl_q && to_cnt == timeout_i ##1 scl_s == $past(scl_s)
                                   |-> irq_raw_o[ics_pkg::IR_TOUT])
    else $error("Timeout not flagged.");
  a_flag_sticky: assert property (irq_raw_o[ics_pkg::IR_BYTE] && !irq_clr_i[ics_pkg::IR_BYTE]
                                  |=> irq_raw_o[ics_pkg::IR_BYTE])
    else $error("Raw flag dropped without a clear.");
  a_slave_limit: assert property (s_cnt <= ics_pkg::SL_MAX)
    else $error("Slave stored more than 32 bytes.");
  a_end_opcode: assert property (m_st == M_FETCH && f_op == ics_pkg::OP_END |=> m_st == M_HOLD)
    else $error("END command did not hold the bus.");

  c_end_hold: cover property (m_st == M_HOLD ##[1:1000] m_st == M_FETCH);
  c_slave_hit: cover property ($rose(s_hit));
  c_master_read: cover property (m_wr);
  c_arb_lost: cover property (ev_arb);
endmodule
`default_nettype wire

// [sim/ics_slave_model.sv]
// Purpose: Behavioural target on the shared serial bus, seven-bit or ten-bit header.
// Assumes: Both lines are pulled up; pull_o high pulls SDA low.
// Notes:   Acknowledges when addressed, answers reads with RD.
`timescale 1ns/10ps
`default_nettype none
module ics_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter logic [9:0] WIDE = 10'h14b,
  parameter logic [7:0] RD   = 8'hc5
) (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            pull_o,
  output logic      [7:0] last_o,
  output logic            mack_o
);
  logic [7:0] sh;
  logic       hit;
  initial begin
    pull_o = 1'b0;
    last_o = 8'h00;
    mack_o = 1'b0;
  end
  // A STOP ends the transfer in progress and frees SDA.
  always @(posedge sda_i) begin
    if (scl_i) begin
      disable xfer;
      pull_o = 1'b0;
    end
  end
  always @(negedge sda_i) begin : xfer
    if (scl_i) begin
      repeat (8) @(posedge scl_i) sh = {sh[6:0], sda_i};
      hit = (sh[7:1] == ADDR) || (sh[7:1] == {5'h1e, WIDE[9:8]});
      @(negedge scl_i) pull_o = hit;
      @(negedge scl_i) pull_o = 1'b0;
      if (hit && sh[0]) begin
        mack_o = 1'b0;
        while (!mack_o) begin
          for (int i = 7; i >= 0; i--) begin
            pull_o = ~RD[i];
            @(negedge scl_i);
          end
          pull_o = 1'b0;
          @(posedge scl_i) mack_o = sda_i;
          @(negedge scl_i);
        end
      end else if (hit) begin
        forever begin
          repeat (8) @(posedge scl_i) sh = {sh[6:0], sda_i};
          last_o = sh;
          @(negedge scl_i) pull_o = 1'b1;
          @(negedge scl_i) pull_o = 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Purpose: Self-checking bench of the controller in master role.
// Assumes: Quarter bit of 4 cycles, so one bit lasts 160 ns.
// Notes:   Stimulus changes on the falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [6:0] SA = 7'h2a;
  logic        mclk_i, rst_i, launch, cmd_we, ram_we, irq, busy, held, scl_oe, sda_oe, pull, mack;
  logic        ms, addrd, scl_d, sda_d;
  logic [19:0] tmo;
  logic [3:0]  cmd_idx;
  logic [13:0] cmd_wd;
  logic [4:0]  ram_addr;
  logic [7:0]  ram_wd, ram_rd, last, d;
  logic [7:0]  tx_thr, rx_thr;
  logic [9:0]  mask, clr, raw;
  logic [15:0] done;
  wire logic   scl = ~scl_oe;
  wire logic   sda = ~(sda_oe | pull);
  int          errors, n_compared, cyc;
  ics_top #(.TO_W(20), .QTR(4)) ics_top_i (.mclk_i(mclk_i), .rst_i(rst_i), .ms_mode_i(ms),
    .launch_bit_i(launch), .slave_wide_addr_enable_i(1'b0), .reg_ptr_en_i(1'b0), .own_addr_i(10'h000),
    .tx_thres_i(tx_thr), .rx_thres_i(rx_thr), .timeout_i(tmo), .cmd_we_i(cmd_we), .cmd_idx_i(cmd_idx),
    .cmd_wdata_i(cmd_wd), .ram_we_i(ram_we), .ram_addr_i(ram_addr), .ram_wdata_i(ram_wd), .ram_rdata_o(ram_rd),
    .irq_mask_i(mask), .irq_clr_i(clr), .irq_raw_o(raw), .irq_o(irq), .cmd_done_o(done), .bus_busy_o(busy),
    .slave_addressed_o(addrd), .master_held_o(held), .scl_i(scl), .scl_o(scl_d), .scl_oe_o(scl_oe), .sda_i(sda),
    .sda_o(sda_d), .sda_oe_o(sda_oe));
  ics_slave_model #(.ADDR(SA), .RD(8'hc5)) ics_slave_model_i (.scl_i(scl), .sda_i(sda), .pull_o(pull),
    .last_o(last), .mack_o(mack));
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic give_verdict();
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [13:0] cw(input logic [2:0] op, input logic [2:0] ack, input logic [7:0] n);
    return {op, ack, n};
  endfunction
  task automatic put_cmd(input logic [3:0] i, input logic [13:0] w);
    @(negedge mclk_i) {cmd_we, cmd_idx, cmd_wd} = {1'b1, i, w};
    @(negedge mclk_i) cmd_we = 1'b0;
  endtask
  task automatic put_ram(input logic [4:0] a, input logic [7:0] v);
    @(negedge mclk_i) {ram_we, ram_addr, ram_wd} = {1'b1, a, v};
    @(negedge mclk_i) ram_we = 1'b0;
  endtask
  task automatic pulse(input logic [9:0] c, input logic l);
    @(negedge mclk_i) {clr, launch} = {c, l};
    @(negedge mclk_i) {clr, launch} = 11'h000;
  endtask
  task automatic wait_bit(input int b);
    for (int k = 0; k < 5000 && raw[b] !== 1'b1; k++) @(negedge mclk_i);
    chk("wait_flag", 8'h01, raw[b]);
    repeat (4) @(negedge mclk_i);
  endtask
  initial begin
    {rst_i, ms, tmo} = {1'b1, 1'b1, 20'h00032};
    {launch, cmd_we, cmd_idx, cmd_wd, ram_we, ram_addr, ram_wd, mask, clr} = 54'h0;
    {errors, n_compared, cyc, tx_thr, rx_thr} = {96'h0, 8'h02, 8'h01};
    repeat (10) @(negedge mclk_i);
    chk("oe_in_reset", 8'h00, {scl_d, sda_d, addrd, scl_oe, sda_oe, irq, busy});
    rst_i = 1'b0;
    repeat (40) @(negedge mclk_i);
    chk("timeout_early", 8'h00, raw[ics_pkg::IR_TOUT]);
    repeat (30) @(negedge mclk_i);
    chk("timeout_late", 8'h01, raw[ics_pkg::IR_TOUT]);
    mask[ics_pkg::IR_TOUT] = 1'b1;
    repeat (2) @(negedge mclk_i);
    chk("irq_masked_in", 8'h01, irq);
    mask = 10'h000;
    repeat (2) @(negedge mclk_i);
    chk("irq_masked_out", 8'h00, irq);
    pulse(10'h3ff, 1'b0);
    chk("raw_cleared", 8'h00, raw[7:0]);
    ms = 1'b0;
    pulse(10'h000, 1'b1);
    repeat (20) @(negedge mclk_i);
    chk("launch_refused", 8'h00, {held, busy, scl_oe, sda_oe, addrd, done[0]});
    ms = 1'b1;
    put_ram(5'h00, 8'hf2);
    put_ram(5'h01, 8'h4b);
    put_ram(5'h02, 8'h96);
    put_cmd(4'h0, cw(ics_pkg::OP_START, 3'h0, 8'h00));
    put_cmd(4'h1, cw(ics_pkg::OP_WRITE, 3'h1, 8'h03));
    put_cmd(4'h2, cw(ics_pkg::OP_STOP, 3'h0, 8'h00));
    pulse(10'h000, 1'b1);
    wait_bit(ics_pkg::IR_COMP);
    chk("flags_write", 8'h69, raw[7:0]);
    chk("target_byte", 8'h96, last);
    chk("cmd_done", 8'h07, done[7:0]);
    pulse(10'h3ff, 1'b0);
    put_ram(5'h00, {7'h11, 1'b0});
    pulse(10'h000, 1'b1);
    wait_bit(ics_pkg::IR_COMP);
    chk("ack_error", 8'h01, raw[ics_pkg::IR_ACKERR]);
    pulse(10'h3ff, 1'b0);
    put_ram(5'h00, {SA, 1'b0});
    put_cmd(4'h1, cw(ics_pkg::OP_WRITE, 3'h1, 8'h01));
    put_cmd(4'h2, cw(ics_pkg::OP_END, 3'h0, 8'h00));
    pulse(10'h000, 1'b1);
    wait_bit(ics_pkg::IR_END);
    repeat (40) @(negedge mclk_i);
    chk("held", 8'h07, {held, scl_oe, busy});
    chk("no_stop", 8'h00, raw[ics_pkg::IR_COMP]);
    put_ram(5'h00, 8'h3c);
    put_cmd(4'h0, cw(ics_pkg::OP_WRITE, 3'h1, 8'h01));
    put_cmd(4'h1, cw(ics_pkg::OP_STOP, 3'h0, 8'h00));
    pulse(10'h3ff, 1'b0);
    pulse(10'h000, 1'b1);
    wait_bit(ics_pkg::IR_COMP);
    chk("resumed_byte", 8'h3c, last);
    chk("released", 8'h00, {held, scl_oe});
    pulse(10'h3ff, 1'b0);
    put_ram(5'h00, {SA, 1'b1});
    put_cmd(4'h0, cw(ics_pkg::OP_START, 3'h0, 8'h00));
    put_cmd(4'h1, cw(ics_pkg::OP_WRITE, 3'h1, 8'h01));
    put_cmd(4'h2, cw(ics_pkg::OP_READ, 3'h4, 8'h01));
    put_cmd(4'h3, cw(ics_pkg::OP_STOP, 3'h0, 8'h00));
    pulse(10'h000, 1'b1);
    wait_bit(ics_pkg::IR_COMP);
    chk("master_nack", 8'h01, mack);
    chk("rx_chunk", 8'h01, raw[ics_pkg::IR_RXCH]);
    @(negedge mclk_i) ram_addr = 5'h00;
    repeat (2) @(negedge mclk_i);
    chk("read_store", 8'hc5, ram_rd);
    give_verdict();
  end
endmodule
`default_nettype wire
